//--- nfcfg_buf2.sv
`timescale 1ns/1ps
module nfcfg_buf2
   import nfcfg_pkg::*;
#(
   parameter int WIDTH = 8
)(
   input wire logic clk_sys,            // System clock
   input wire logic rst,                // Sync reset
   input wire logic inValid,            // Word offered
   output logic inReady,                // Space free
   input wire logic [WIDTH-1:0] inData, // Word in
   output logic outValid,               // Word held
   input wire logic outReady,           // Receiver takes
   output logic [WIDTH-1:0] outData     // Word out
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic [1:0] count;
      logic rdPtr;
      logic wrPtr;
   } nfcfg_bst_t;
   nfcfg_bst_t st, next_st;
   logic push, pop;

   assign inReady = (st.count != 2'd2);
   assign outValid = (st.count != 2'd0);
   assign outData = st.mem[st.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wrPtr] = inData;
         next_st.wrPtr = ~st.wrPtr;
      end
      if (pop)
         next_st.rdPtr = ~st.rdPtr;
      next_st.count = st.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   property p_no_overflow;
      @(posedge clk_sys) disable iff (rst)
      !inReady |=> $stable(st.mem);
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("buffer accepted while full");
   property p_keep_word;
      @(posedge clk_sys) disable iff (rst)
      outValid && !outReady |=> outValid && $stable(outData);
   endproperty
   a_keep_word: assert property (p_keep_word) else $error("stalled word changed");
endmodule

//--- nfcfg_flash_model.sv
`timescale 1ns/1ps
module nfcfg_flash_model
   import nfcfg_pkg::*;
(
   input wire logic [7:0] dqIn, // Bus level
   output logic [7:0] dqOut,    // Device data
   input wire logic cle,        // Command latch
   input wire logic ale,        // Address latch
   input wire logic weN,        // Write strobe
   input wire logic reN,        // Read strobe
   output logic rbN,            // Ready/busy
   input wire logic ptPin,      // Protect strap
   input wire logic badUid      // Corrupt identifier
);
   logic [7:0] arrMode = ARRAY_MODE_RST;
   logic [7:0] blkProt = BLOCK_PROT_RST;
   logic [7:0] fAddr = 8'h00_00;
   logic [7:0] cmd = 8'h00_00;
   logic [7:0] last = 8'h00_00;
   logic [7:0] par [FEAT_BYTES];
   logic stat = 1'b0;
   logic drive = 1'b0;
   int idx = 0;
   event goBusy;
   initial rbN = 1'b1;
   function automatic logic [7:0] rd_byte(int i);
      logic [7:0] b;
      b = 8'h00_A5 ^ 8'(i % UID_HALF);
      if (stat)
         return rbN ? STAT_READY_MASK : 8'h00_00;
      if (cmd == CMD_UID_READ)
         return (i % UID_BYTES < UID_HALF) ? b : ~b ^ 8'(badUid);
      if (i != 0)
         return PARAM_ZERO;
      return fAddr == FA_ARRAY_MODE ? arrMode : fAddr == FA_BLOCK_PROT ? blkProt : PARAM_ZERO;
   endfunction
   always @(goBusy)
   begin
      rbN = 1'b0;
      #300;
      rbN = 1'b1;
   end
   always @(posedge weN)
   begin
      if (cle)
      begin
         if (dqIn == CMD_STATUS)
            stat = 1'b1;
         else if (dqIn == CMD_READ)
            stat = 1'b0;
         else if (dqIn != CMD_RESET)
         begin
            cmd = dqIn;
            stat = 1'b0;
         end
      end
      else if (ale)
      begin
         fAddr = dqIn;
         idx = 0;
         if (cmd != CMD_SET_FEAT)
            ->goBusy;
      end
      else if (cmd == CMD_SET_FEAT && idx < FEAT_BYTES)
      begin
         par[idx] = dqIn;
         idx = idx + 1;
         if (idx == FEAT_BYTES)
         begin
            if (fAddr == FA_ARRAY_MODE)
               arrMode = par[0];
            else if (fAddr == FA_BLOCK_PROT && ptPin && !blkProt[BP_SOLID])
               blkProt = par[0] & 8'h00_3F;
            ->goBusy;
         end
      end
   end
   always @(negedge reN)
   begin
      last = rd_byte(idx);
      if (!stat)
         idx = idx + 1;
      drive = 1'b1;
   end
   always @(posedge reN)
      drive <= #5 1'b0;
   assign dqOut = drive ? last : ~last;
endmodule

//--- nfcfg_host.sv
`timescale 1ns/1ps
module nfcfg_host
   import nfcfg_pkg::*;
#(
   parameter int STROBE = STROBE_CYC
)(
   input wire logic clk_sys,        // System clock
   input wire logic rst,            // Sync reset
   input wire logic reqValid,       // Operation request
   output logic reqReady,           // Idle, request taken
   input wire nfcfg_op_t reqOp,     // Operation kind
   input wire logic [7:0] reqAddr,  // Feature address
   input wire logic [7:0] reqParam, // First parameter byte for set
   input wire logic [3:0] uidCopy,  // Identifier copy select, unused; the first copy is checked
   output logic rdValid,            // Read byte valid
   input wire logic rdReady,        // Receiver ready
   output logic [7:0] rdData,       // Read byte
   output logic uidOk,              // First copy passed check
   output logic done,               // Operation finished pulse
   output logic refused,            // Request refused pulse
   output logic [7:0] nfDqOut,      // Flash data out
   output logic nfDqOe,             // Flash data drive enable
   input wire logic [7:0] nfDqIn,   // Flash data in
   output logic nfCle,              // Command latch
   output logic nfAle,              // Address latch
   output logic nfWeN,              // Write strobe
   output logic nfReN,              // Read strobe
   input wire logic nfRbN,          // Ready/busy
   input wire logic protectEnablePin // Device protect strap level
);
   typedef enum logic [3:0] {S_IDLE, S_CMD, S_ADDR, S_WDATA, S_WAIT, S_POLL,
      S_POLLRD, S_REREAD, S_RDATA, S_DONE} nfcfg_state_t;
   typedef struct packed {
      nfcfg_state_t state;
      nfcfg_bus_t bus;
      nfcfg_op_t op;
      logic [7:0] addr;
      logic [7:0] param;
      logic [5:0] idx;
      logic [5:0] total;
      logic [3:0] tmr;
      logic phase;
      logic [UID_HALF-1:0] cmpOk;
      logic [UID_HALF-1:0][7:0] low;
      logic uidOk;
      logic done;
      logic refused;
   } nfcfg_hst_t;
   nfcfg_hst_t st, next_st;
   logic [1:0] rbSync, peSync;
   logic [1:0][7:0] dqSync;
   logic bufReady, push;
   logic [7:0] capByte;

   function automatic logic [7:0] cmdFor(nfcfg_op_t o);
      unique case (o)
         NFCFG_OP_UID: cmdFor = CMD_UID_READ;
         NFCFG_OP_SET: cmdFor = CMD_SET_FEAT;
         default: cmdFor = CMD_GET_FEAT;
      endcase
   endfunction

   function automatic logic [7:0] paramFor(logic [7:0] a, logic [7:0] p, logic [5:0] i);
      // Only byte one carries content; 90h mode values, A0h field layout
      paramFor = (i == 6'd0) ? p : PARAM_ZERO;
      if (a == FA_BLOCK_PROT)
         paramFor[7:BP_RANGE_HI+1] = 2'b00;
   endfunction

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rbSync <= '0;
         peSync <= '0;
         dqSync <= '0;
      end
      else
      begin
         rbSync <= {rbSync[0], nfRbN};
         peSync <= {peSync[0], protectEnablePin};
         dqSync <= {dqSync[0], nfDqIn};
      end
   end

   // Read strobe holds the bus steady through both stages
   assign capByte = dqSync[1];
   assign push = (st.state == S_RDATA) && st.phase && (st.tmr == 4'd0)
      && (st.op != NFCFG_OP_SET);
   assign reqReady = (st.state == S_IDLE);
   assign nfDqOut = st.bus.dq;
   assign nfDqOe = st.bus.dqOe;
   assign nfCle = st.bus.cle;
   assign nfAle = st.bus.ale;
   assign nfWeN = st.bus.weN;
   assign nfReN = st.bus.reN;
   assign uidOk = st.uidOk;
   assign done = st.done;
   assign refused = st.refused;

   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.refused = 1'b0;
      if (st.tmr != 4'd0)
         next_st.tmr = st.tmr - 4'd1;
      else
      unique case (st.state)
         S_IDLE:
         begin
            next_st.bus = '{dq: 8'h00_00, dqOe: 1'b0, cle: 1'b0, ale: 1'b0,
               weN: 1'b1, reN: 1'b1};
            if (reqValid)
            begin
               if (reqOp != NFCFG_OP_UID && ((reqAddr == FA_BLOCK_PROT && !peSync[1])
                  || (reqAddr != FA_BLOCK_PROT && reqAddr != FA_ARRAY_MODE)))
                  next_st.refused = 1'b1;
               else
               begin
                  next_st.op = reqOp;
                  next_st.addr = (reqOp == NFCFG_OP_UID) ? UID_ADDR : reqAddr;
                  next_st.param = reqParam;
                  next_st.total = (reqOp == NFCFG_OP_UID) ? 6'(UID_BYTES)
                     : 6'(FEAT_BYTES);
                  next_st.idx = '0;
                  next_st.phase = 1'b0;
                  next_st.cmpOk = '1;
                  next_st.state = S_CMD;
               end
            end
         end
         S_CMD, S_ADDR, S_POLL, S_REREAD, S_WDATA:
         begin
            // Write cycle: setup with strobe low, then rise latches
            next_st.bus.dqOe = 1'b1;
            next_st.bus.cle = (st.state != S_ADDR) && (st.state != S_WDATA);
            next_st.bus.ale = (st.state == S_ADDR);
            unique case (st.state)
               S_CMD: next_st.bus.dq = cmdFor(st.op);
               S_ADDR: next_st.bus.dq = st.addr;
               S_POLL: next_st.bus.dq = CMD_STATUS;
               S_REREAD: next_st.bus.dq = CMD_READ;
               default: next_st.bus.dq = paramFor(st.addr, st.param, st.idx);
            endcase
            next_st.bus.weN = st.phase;
            next_st.phase = ~st.phase;
            next_st.tmr = 4'(STROBE - 1);
            if (st.phase)
            begin
               next_st.phase = 1'b0;
               unique case (st.state)
                  S_CMD: next_st.state = S_ADDR;
                  S_ADDR: next_st.state = (st.op == NFCFG_OP_SET) ? S_WDATA : S_WAIT;
                  S_POLL: next_st.state = S_POLLRD;
                  S_REREAD: next_st.state = S_RDATA;
                  default:
                  begin
                     next_st.idx = st.idx + 6'd1;
                     if (st.idx == 6'(FEAT_BYTES - 1))
                        next_st.state = S_WAIT;
                  end
               endcase
            end
         end
         S_WAIT:
         begin
            next_st.bus.dqOe = 1'b0;
            next_st.bus.cle = 1'b0;
            next_st.bus.ale = 1'b0;
            if (rbSync[1])
               next_st.state = S_POLL;
         end
         S_POLLRD:
         begin
            next_st.bus.dqOe = 1'b0;
            next_st.bus.cle = 1'b0;
            next_st.bus.reN = st.phase;
            next_st.phase = ~st.phase;
            next_st.tmr = 4'(STROBE - 1);
            if (st.phase && (capByte & STAT_READY_MASK) != 8'h00_00)
            begin
               next_st.phase = 1'b0;
               next_st.bus.reN = 1'b1;
               next_st.state = (st.op == NFCFG_OP_SET) ? S_DONE : S_REREAD;
            end
         end
         S_RDATA:
         begin
            next_st.bus.dqOe = 1'b0;
            next_st.bus.cle = 1'b0;
            if (!st.phase)
            begin
               if (bufReady)
               begin
                  next_st.bus.reN = 1'b0;
                  next_st.phase = 1'b1;
                  next_st.tmr = 4'(STROBE - 1);
               end
            end
            else
            begin
               next_st.bus.reN = 1'b1;
               next_st.phase = 1'b0;
               next_st.tmr = 4'(STROBE - 1);
               // Output read in order, never relocated
               next_st.idx = st.idx + 6'd1;
               if (st.op == NFCFG_OP_UID)
               begin
                  if (st.idx < 6'(UID_HALF))
                     next_st.low[st.idx[3:0]] = capByte;
                  else if ((st.low[st.idx[3:0]] ^ capByte) != UID_VALID)
                     next_st.cmpOk[st.idx[3:0]] = 1'b0;
               end
               if (st.idx == st.total - 6'd1)
                  next_st.state = S_DONE;
            end
         end
         default:
         begin
            next_st.uidOk = (st.op == NFCFG_OP_UID) && (&st.cmpOk);
            next_st.done = 1'b1;
            next_st.state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st <= '0;
         st.state <= S_IDLE;
         st.bus.weN <= 1'b1;
         st.bus.reN <= 1'b1;
      end
      else
         st <= next_st;
   end

   nfcfg_buf2 #(.WIDTH(8)) u_buf (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(push),
      .inReady(bufReady),
      .inData(capByte),
      .outValid(rdValid),
      .outReady(rdReady),
      .outData(rdData)
   );

   property p_reserved_refused;
      @(posedge clk_sys) disable iff (rst)
      st.state == S_IDLE && st.tmr == 0 && reqValid && reqOp == NFCFG_OP_SET
         && reqAddr != FA_BLOCK_PROT && reqAddr != FA_ARRAY_MODE |=> refused;
   endproperty
   a_reserved_refused: assert property (p_reserved_refused) else $error("reserved write sent");
   property p_no_pin_a0;
      @(posedge clk_sys) disable iff (rst)
      st.state == S_IDLE && reqValid && reqAddr == FA_BLOCK_PROT && reqOp != NFCFG_OP_UID
         && !peSync[1] |=> st.state == S_IDLE;
   endproperty
   a_no_pin_a0: assert property (p_no_pin_a0) else $error("A0h sent without strap");
   property p_addr_after_cmd;
      @(posedge clk_sys) disable iff (rst)
      st.state == S_CMD && st.phase && st.tmr == 0 |=> st.state == S_ADDR;
   endproperty
   a_addr_after_cmd: assert property (p_addr_after_cmd) else $error("no address after cmd");
   property p_four_bytes;
      @(posedge clk_sys) disable iff (rst)
      st.state == S_WDATA && st.tmr == 0 && st.phase && st.idx == 6'(FEAT_BYTES - 1)
         |=> st.state == S_WAIT;
   endproperty
   a_four_bytes: assert property (p_four_bytes) else $error("param count wrong");
   property p_zero_tail;
      @(posedge clk_sys) disable iff (rst)
      st.state == S_WDATA && st.idx != 0 && st.bus.dqOe && !st.bus.weN |-> st.bus.dq == 8'h00_00;
   endproperty
   a_zero_tail: assert property (p_zero_tail) else $error("nonzero P2-P4");
   property p_reread;
      @(posedge clk_sys) disable iff (rst)
      st.state == S_REREAD && !st.bus.weN |-> st.bus.dq == CMD_READ && st.bus.cle;
   endproperty
   a_reread: assert property (p_reread) else $error("reread not 00h");
   property p_poll_then_done;
      @(posedge clk_sys) disable iff (rst)
      st.op == NFCFG_OP_SET && $rose(st.state == S_DONE) |-> $past(st.state) == S_POLLRD;
   endproperty
   a_poll_then_done: assert property (p_poll_then_done) else $error("done without poll");
   property p_strobes_excl;
      @(posedge clk_sys) disable iff (rst)
      !(nfWeN == 1'b0 && nfReN == 1'b0) && !(nfCle && nfAle);
   endproperty
   a_strobes_excl: assert property (p_strobes_excl) else $error("strobe clash");
   c_uid: cover property (@(posedge clk_sys) disable iff (rst) done && uidOk);
   c_set: cover property (@(posedge clk_sys) disable iff (rst) done && st.op == NFCFG_OP_SET);
   c_stall: cover property (@(posedge clk_sys) disable iff (rst) rdValid && !rdReady);
endmodule

//--- nfcfg_host_tb.sv
`timescale 1ns/1ps
module nfcfg_host_tb
   import nfcfg_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   logic rdReady = 1'b1;
   logic ptPin = 1'b1;
   logic badUid = 1'b0;
   logic stall = 1'b0;
   nfcfg_op_t reqOp = NFCFG_OP_GET;
   logic [7:0] reqAddr = 8'h00_00;
   logic [7:0] reqParam = 8'h00_00;
   logic [7:0] rdData, nfDqOut, devDq, dqWire, v, blkExp;
   logic reqReady, rdValid, uidOk, done, refused, nfDqOe, nfCle, nfAle, nfWeN, nfReN, nfRbN;
   logic [7:0] rxq [$];
   logic [7:0] codes [3] = '{MODE_OTP, MODE_OTP_PROT, MODE_NORMAL};
   int fails = 0;
   int compares = 0;
   int seed = 39398;
   nfcfg_host uut (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
      .reqOp(reqOp), .reqAddr(reqAddr), .reqParam(reqParam), .uidCopy(4'h0), .rdValid(rdValid),
      .rdReady(rdReady), .rdData(rdData), .uidOk(uidOk), .done(done), .refused(refused),
      .nfDqOut(nfDqOut), .nfDqOe(nfDqOe), .nfDqIn(dqWire), .nfCle(nfCle), .nfAle(nfAle),
      .nfWeN(nfWeN), .nfReN(nfReN), .nfRbN(nfRbN), .protectEnablePin(ptPin));
   nfcfg_flash_model dev (.dqIn(dqWire), .dqOut(devDq), .cle(nfCle), .ale(nfAle), .weN(nfWeN),
      .reN(nfReN), .rbN(nfRbN), .ptPin(ptPin), .badUid(badUid));
   assign dqWire = nfDqOe ? nfDqOut : devDq;
   always #5 clk_sys = ~clk_sys;
   // Receiver with random and forced stalls
   always @(posedge clk_sys)
   begin
      if (rdValid === 1'b1 && rdReady === 1'b1)
         rxq.push_back(rdData);
      rdReady <= #1 !stall && ($random(seed) % 4 != 0);
   end
   task stop_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(string name, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", name, e, g);
         fails++;
      end
   endtask
   function automatic logic [7:0] uid_exp(int i);
      return i < UID_HALF ? 8'h00_A5 ^ 8'(i) : ~(8'h00_A5 ^ 8'(i - UID_HALF));
   endfunction
   task run_op(nfcfg_op_t op, logic [7:0] a, logic [7:0] p, logic rej, int n);
      int k;
      k = 0;
      @(posedge clk_sys);
      #1;
      reqOp = op;
      reqAddr = a;
      reqParam = p;
      reqValid = 1'b1;
      rxq.delete();
      while (reqReady !== 1'b1 && k < 100)
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      @(posedge clk_sys);
      #1;
      reqValid = 1'b0;
      k = 0;
      while (done !== 1'b1 && refused !== 1'b1 && k < 5000)
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      chk("refused", 8'(rej), 8'(refused));
      chk("done", 8'(!rej), 8'(done));
      k = 0;
      while (rxq.size() < n && k < 400)
      begin
         @(posedge clk_sys);
         k++;
      end
      chk("count", 8'(n), 8'(rxq.size()));
   endtask
   task get_chk(logic [7:0] a, logic [7:0] p1);
      run_op(NFCFG_OP_GET, a, 8'h00_00, 1'b0, FEAT_BYTES);
      for (int i = 0; i < FEAT_BYTES; i++)
         chk("param", i == 0 ? p1 : PARAM_ZERO, rxq[i]);
   endtask
   initial
   begin
      #900_000;
      fails++;
      stop_test;
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      #1 rst = 1'b0;
      get_chk(FA_ARRAY_MODE, ARRAY_MODE_RST);
      get_chk(FA_BLOCK_PROT, BLOCK_PROT_RST);
      $display("test defaults done");
      stall = 1'b1;
      fork
         #3000 stall = 1'b0;
      join_none
      run_op(NFCFG_OP_UID, UID_ADDR, 8'h00_00, 1'b0, UID_BYTES);
      for (int i = 0; i < UID_BYTES; i++)
         chk("uid", uid_exp(i), rxq[i]);
      chk("uidOk", 8'h00_01, 8'(uidOk));
      badUid = 1'b1;
      run_op(NFCFG_OP_UID, UID_ADDR, 8'h00_00, 1'b0, UID_BYTES);
      chk("uidOk", 8'h00_00, 8'(uidOk));
      badUid = 1'b0;
      $display("test identifier done");
      foreach (codes[i])
      begin
         run_op(NFCFG_OP_SET, FA_ARRAY_MODE, codes[i], 1'b0, 0);
         get_chk(FA_ARRAY_MODE, codes[i]);
      end
      v = 8'($random(seed)) & 8'h00_FE;
      blkExp = v & 8'h00_3F;
      run_op(NFCFG_OP_SET, FA_BLOCK_PROT, v, 1'b0, 0);
      get_chk(FA_BLOCK_PROT, blkExp);
      $display("test set feature done");
      repeat (3)
      begin
         v = 8'($random(seed));
         if (v == FA_ARRAY_MODE || v == FA_BLOCK_PROT)
            v = 8'h00_91;
         run_op(NFCFG_OP_SET, v, 8'($random(seed)), 1'b1, 0);
         run_op(NFCFG_OP_GET, v, 8'h00_00, 1'b1, 0);
      end
      ptPin = 1'b0;
      repeat (3) @(posedge clk_sys);
      run_op(NFCFG_OP_SET, FA_BLOCK_PROT, 8'h00_00, 1'b1, 0);
      run_op(NFCFG_OP_GET, FA_BLOCK_PROT, 8'h00_00, 1'b1, 0);
      ptPin = 1'b1;
      repeat (3) @(posedge clk_sys);
      get_chk(FA_BLOCK_PROT, blkExp);
      $display("test refusals done");
      @(posedge clk_sys);
      #1 rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      get_chk(FA_ARRAY_MODE, MODE_NORMAL);
      get_chk(FA_BLOCK_PROT, blkExp);
      run_op(NFCFG_OP_SET, FA_BLOCK_PROT, 8'h00_29, 1'b0, 0);
      get_chk(FA_BLOCK_PROT, 8'h00_29);
      run_op(NFCFG_OP_SET, FA_BLOCK_PROT, 8'h00_00, 1'b0, 0);
      get_chk(FA_BLOCK_PROT, 8'h00_29);
      $display("test retention and lock done");
      stop_test;
   end
endmodule

//--- nfcfg_pkg.sv
package nfcfg_pkg;
   // Command opcodes
   localparam logic [7:0] CMD_UID_READ = 8'h00_ED;
   localparam logic [7:0] CMD_SET_FEAT = 8'h00_EF;
   localparam logic [7:0] CMD_GET_FEAT = 8'h00_EE;
   localparam logic [7:0] CMD_STATUS = 8'h00_70;
   localparam logic [7:0] CMD_READ = 8'h00_00;
   localparam logic [7:0] CMD_RND_OUT = 8'h00_05;
   localparam logic [7:0] CMD_RND_CONF = 8'h00_E0;
   localparam logic [7:0] CMD_RESET = 8'h00_FF;
   localparam logic [7:0] UID_ADDR = 8'h00_00;
   // Feature addresses and defaults
   localparam logic [7:0] FA_ARRAY_MODE = 8'h00_90;
   localparam logic [7:0] FA_BLOCK_PROT = 8'h00_A0;
   localparam logic [7:0] ARRAY_MODE_RST = 8'h00_00;
   localparam logic [7:0] BLOCK_PROT_RST = 8'h00_38;
   localparam logic [7:0] MODE_NORMAL = 8'h00_00;
   localparam logic [7:0] MODE_OTP = 8'h00_01;
   localparam logic [7:0] MODE_OTP_PROT = 8'h00_03;
   localparam logic [7:0] PARAM_ZERO = 8'h00_00;
   localparam logic [7:0] UID_VALID = 8'h00_FF;
   localparam logic [7:0] STAT_READY_MASK = 8'h00_40;
   // Block protection field positions
   localparam int BP_RANGE_HI = 5;
   localparam int BP_RANGE_LO = 3;
   localparam int BP_INVERT = 2;
   localparam int BP_COMPL = 1;
   localparam int BP_SOLID = 0;
   // Sizes
   localparam int UID_BYTES = 32;
   localparam int UID_HALF = 16;
   localparam int UID_COPIES = 16;
   localparam int FEAT_BYTES = 4;
   // Bus timing, 10 ns clock
   localparam int CLK_NS = 10;
   localparam int T_STROBE_NS = 25;
   localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {NFCFG_OP_UID, NFCFG_OP_SET, NFCFG_OP_GET} nfcfg_op_t;

   typedef struct packed {
      logic [7:0] dq;
      logic dqOe;
      logic cle;
      logic ale;
      logic weN;
      logic reN;
   } nfcfg_bus_t;
endpackage
